// [pkg/dmr_pkg.sv]
// constants, field positions and carrier types for the mode register decode block
// assumes a ddr3-style command bus sampled on the memory clock and a separate system clock
package dmr_pkg;
   localparam int          ADDR_W      = 13;
   localparam int          AL_DEPTH    = 16;
   localparam logic [1:0]  BANK_MR0    = 2'h0;
   localparam logic [1:0]  BANK_MR1    = 2'h1;
   localparam logic [1:0]  BANK_MR2    = 2'h2;
   localparam logic [1:0]  BANK_MR3    = 2'h3;
   localparam logic [12:0] MR_RESET    = 13'h0000;
   localparam int          CMD_AP_BIT  = 10;
   localparam logic [2:0]  RTT_NOM_OFF = 3'h0;
   // first mode register fields
   localparam int          MR1_DS_LO   = 1;
   localparam int          MR1_DS_HI   = 5;
   localparam int          MR1_RTT_B0  = 2;
   localparam int          MR1_RTT_B1  = 6;
   localparam int          MR1_RTT_B2  = 9;
   localparam int          MR1_AL_LO   = 3;
   localparam int          MR1_QOFF    = 12;
   localparam logic [1:0]  AL_ZERO     = 2'h0;
   localparam logic [1:0]  AL_CL_M1    = 2'h1;
   localparam logic [1:0]  AL_CL_M2    = 2'h2;
   // zero mode register cas latency field
   localparam int          MR0_CL_LO   = 4;
   localparam logic [4:0]  CL_BASE     = 5'h04;
   // second mode register fields
   localparam int          MR2_PARTIAL_ARRAY_REFRESH_LO = 0;
   localparam int          MR2_CWL_LO  = 3;
   localparam int          MR2_SRT     = 7;
   localparam int          MR2_RTTW_LO = 9;
   localparam logic [3:0]  CWL_BASE    = 4'h5;
   localparam logic [2:0]  CWL_MAX_CODE = 3'h4;
   localparam logic [1:0]  RTTW_OFF    = 2'h0;
   localparam logic [1:0]  RTTW_QUARTER = 2'h1;
   localparam logic [1:0]  RTTW_HALF   = 2'h2;
   localparam logic [1:0]  RTTW_RSVD   = 2'h3;

   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [2:0]        ba;
      logic [ADDR_W-1:0] addr;
   } dmr_cmd_t;

   typedef enum logic [1:0] {DMR_TERM_OFF, DMR_TERM_QUARTER, DMR_TERM_HALF, DMR_TERM_RSVD} dmr_term_t;

   typedef struct packed {
      logic [1:0] drive_strength;
      logic [2:0] rtt_nom;
      dmr_term_t  rtt_wr;
      logic [4:0] additive_latency;
      logic [4:0] cas_latency;
      logic [3:0] write_cas_latency;
      logic       cwl_reserved;
      logic [5:0] read_latency_total;
      logic [5:0] write_latency_total;
      logic       output_off;
      logic       self_refresh_double;
      logic [2:0] partial_array_refresh;
      logic [7:0] keep_bank_mask;
   } dmr_cfg_t;
endpackage

// [tb/dmr_asserts.sv]
// port-level checks for the mode register decode block
// assumes reset spans at least three ck_mem edges and both clocks run free
module dmr_asserts
   import dmr_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              reset,
   input wire logic              ck_mem,
   input wire dmr_pkg::dmr_cmd_t cmd,
   input wire logic              drive_req,
   input wire logic              odt_pin,
   input wire logic              write_burst,
   input wire logic              rd_issue,
   input wire logic              wr_issue,
   input wire logic              issue_autopre,
   input wire logic              dq_oe_n,
   input wire logic              term_on,
   input wire logic              term_is_wr,
   input wire dmr_pkg::dmr_cfg_t cfg,
   input wire logic              cfg_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   wire logic rd_c = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && cmd.we_n;
   wire logic wr_c = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
   // cfg lags the link copy, so latency checks only hold while no mode set is in flight
   a_rd_al_zero: assert property (@(posedge ck_mem) disable iff (reset)
      rd_c && cfg_valid && cfg.additive_latency == 5'h00 |=> rd_issue && issue_autopre == $past(cmd.addr[10]))
      else $error("read not issued next cycle");
   a_wr_al_four: assert property (@(posedge ck_mem) disable iff (reset)
      wr_c && cfg.additive_latency == 5'h04 |-> ##5 wr_issue) else $error("write issue delay wrong");
   a_oe_idle: assert property (@(posedge ck_mem) disable iff (reset)
      !drive_req |=> dq_oe_n) else $error("drivers on without request");
   a_term_idle: assert property (@(posedge ck_mem) disable iff (reset)
      !odt_pin |=> !term_on && !term_is_wr) else $error("termination without pin");
   a_term_wr_on: assert property (@(posedge ck_mem) disable iff (reset)
      term_is_wr |-> term_on) else $error("write termination not applied");
   a_rl_sum: assert property (@(posedge clk_sys) disable iff (reset)
      cfg_valid |-> cfg.read_latency_total == cfg.additive_latency + cfg.cas_latency) else $error("read latency sum");
   a_wl_sum: assert property (@(posedge clk_sys) disable iff (reset)
      cfg_valid |-> cfg.write_latency_total == cfg.additive_latency + cfg.write_cas_latency)
      else $error("write latency sum");
   a_cwl_range: assert property (@(posedge clk_sys) disable iff (reset)
      cfg_valid |-> (cfg.cwl_reserved ? cfg.write_cas_latency == 4'h5 : cfg.write_cas_latency inside {[4'h5:4'h9]}))
      else $error("write cas latency out of range");
   c_rd: cover property (@(posedge ck_mem) disable iff (reset) rd_issue);
   c_wr: cover property (@(posedge ck_mem) disable iff (reset) wr_issue);
   c_term: cover property (@(posedge ck_mem) disable iff (reset) term_is_wr);
endmodule

bind dmr_decode dmr_asserts u_dmr_asserts (.clk_sys, .reset, .ck_mem, .cmd, .drive_req, .odt_pin, .write_burst,
   .rd_issue, .wr_issue, .issue_autopre, .dq_oe_n, .term_on, .term_is_wr, .cfg, .cfg_valid);

// [tb/dmr_ctrl_model.sv]
// memory controller model issuing commands on the ck_mem command bus
// assumes the caller waits out link reset before the first command
module dmr_ctrl_model
   import dmr_pkg::*;
(
   input  wire logic              ck_mem,
   output      dmr_pkg::dmr_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 100ps;
   initial cmd = {4'hf, 3'h0, 13'h0000};
   // the controller levels its strobes; this model drives no strobes, so no fly-by skew arises
   // rcw is ras_n, cas_n, we_n
   task automatic send(input logic [2:0] rcw, input logic [2:0] ba, input logic [12:0] addr);
      logic [12:0] a;
      a = (ba[1:0] == BANK_MR2) ? (addr & 13'h06ff) : addr;
      @(posedge ck_mem);
      #1;
      cmd = {1'b0, rcw, ba, a};
      @(posedge ck_mem);
      #1;
      // deselected lines flip so a stale word cannot pass for a held one
      cmd = {4'hf, ~ba, ~a};
      if (rcw == 3'b000) repeat (4) @(posedge ck_mem);
   endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the mode register decode block
// assumes the controller model drives the command bus and the bench the core-side levels
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dmr_pkg::*;
   logic       clk_sys = 1'b0;
   logic       ck_mem = 1'b0;
   logic       reset = 1'b1;
   logic       drive_req = 1'b0;
   logic       odt_pin = 1'b0;
   logic       write_burst = 1'b0;
   logic       rd_issue, wr_issue, issue_autopre, dq_oe_n, term_on, term_is_wr, cfg_valid;
   dmr_cmd_t   cmd;
   dmr_cfg_t   cfg;
   int         fail_count = 0;
   int         cmp_count = 0;
   logic [7:0] keep_tbl [8] = '{8'hff, 8'h0f, 8'h03, 8'h01, 8'hfc, 8'hf0, 8'hc0, 8'h80};
   always #2.5 clk_sys = ~clk_sys;
   always #6 ck_mem = ~ck_mem;
   dmr_decode u_dmr_decode (.clk_sys, .reset, .ck_mem, .cmd, .drive_req, .odt_pin, .write_burst, .rd_issue,
      .wr_issue, .issue_autopre, .dq_oe_n, .term_on, .term_is_wr, .cfg, .cfg_valid);
   dmr_ctrl_model u_dmr_ctrl_model (.ck_mem, .cmd);
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic mode_register_set_command(input logic [1:0] ba, input logic [12:0] a);
      u_dmr_ctrl_model.send(3'b000, {1'b0, ba}, a);
      repeat (10) @(posedge clk_sys);
   endtask
   // counts ck_mem edges from the taking edge to the edge that raises the issue pulse;
   // send returns just after the taking edge, so a zero-latency pulse is already up then
   task automatic issue(input logic wr, input logic a10, input logic [7:0] lat);
      int n;
      u_dmr_ctrl_model.send({2'b10, !wr}, 3'h0, {2'b00, a10, 10'h000});
      for (n = 0; n < 20; n++) begin
         if ((wr ? wr_issue : rd_issue) === 1'b1) break;
         @(posedge ck_mem);
         #1;
      end
      chk("issue delay", lat, 8'(n));
      chk("autopre", {7'h0, a10}, {7'h0, issue_autopre});
   endtask
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #20000;
      fail_count++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      #1 reset = 1'b0;
      repeat (5) @(posedge ck_mem);
      #1;
      chk("oe_n idle", 8'h01, {7'h0, dq_oe_n});
      chk("valid idle", 8'h00, {7'h0, cfg_valid});
      for (int i = 0; i < 8; i++) begin
         mode_register_set_command(BANK_MR2, {2'b00, i[1:0], 1'b0, i[0], 1'b0, i[2:0], i[2:0]});
         chk("cwl", (i < 5) ? 8'(5 + i) : 8'h05, {4'h0, cfg.write_cas_latency});
         chk("cwl rsvd", 8'(i >= 5), {7'h0, cfg.cwl_reserved});
         chk("rtt_wr", 8'(i[1:0]), {6'h0, cfg.rtt_wr});
         chk("srt", 8'(i[0]), {7'h0, cfg.self_refresh_double});
         chk("keep mask", keep_tbl[i], cfg.keep_bank_mask);
         chk("partial_array_refresh", 8'(i), {5'h0, cfg.partial_array_refresh});
         chk("cfg valid", 8'h01, {7'h0, cfg_valid});
      end
      mode_register_set_command(BANK_MR1, 13'h1028);
      chk("strength", 8'h02, {6'h0, cfg.drive_strength});
      chk("al", 8'h03, {3'h0, cfg.additive_latency});
      chk("qoff", 8'h01, {7'h0, cfg.output_off});
      chk("rtt_nom", 8'h00, {5'h0, cfg.rtt_nom});
      chk("rl", 8'h07, {2'h0, cfg.read_latency_total});
      chk("wl", 8'h08, {2'h0, cfg.write_latency_total});
      @(posedge ck_mem);
      #1 {drive_req, odt_pin, write_burst} = 3'b111;
      repeat (3) @(posedge ck_mem);
      #1;
      chk("oe_n off", 8'h01, {7'h0, dq_oe_n});
      chk("term wr", 8'h03, {6'h0, term_is_wr, term_on});
      write_burst = 1'b0;
      repeat (2) @(posedge ck_mem);
      #1;
      chk("term nom off", 8'h00, {6'h0, term_is_wr, term_on});
      odt_pin = 1'b0;
      mode_register_set_command(BANK_MR0, 13'h0010);
      chk("rl cl5", 8'h09, {2'h0, cfg.read_latency_total});
      chk("cl", 8'h05, {3'h0, cfg.cas_latency});
      chk("wl al4", 8'h09, {2'h0, cfg.write_latency_total});
      issue(1'b1, 1'b1, 8'h04);
      issue(1'b0, 1'b0, 8'h04);
      mode_register_set_command(BANK_MR1, 13'h0000);
      chk("oe_n on", 8'h00, {7'h0, dq_oe_n});
      issue(1'b0, 1'b1, 8'h00);
      // mid-run reset: drivers off and config invalid while held, output-off cleared after
      @(posedge clk_sys);
      #1 reset = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
      chk("rst oe_n", 8'h01, {7'h0, dq_oe_n});
      chk("rst valid", 8'h00, {7'h0, cfg_valid});
      chk("rst issue", 8'h00, {6'h0, rd_issue, wr_issue});
      reset = 1'b0;
      repeat (5) @(posedge ck_mem);
      #1;
      chk("oe_n after rst", 8'h00, {7'h0, dq_oe_n});
      conclude();
   end
endmodule

// [verilog/dmr_decode.sv]
// mode register set capture and decode, additive latency delay, driver and termination control
// assumes the command pins are synchronous to ck_mem; config is handed to clk_sys by toggle handshake
// What this block does
// - drive strength taken from A5 and A1
// - nominal and write termination held separately
// - write termination applies even without nominal
// - read/write issue delayed by additive latency
// - read latency is additive plus cas latency
// - write latency is additive plus write cas
// - output disable bit cuts data drivers
// - second register written when bank is two
// - write cas latency five through nine from codes zero to four
// - write termination from A10 and A9
// - temperature bit doubles self refresh rate
// - partial refresh keeps only selected banks
module dmr_decode
   import dmr_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              ck_mem,
   input  wire dmr_pkg::dmr_cmd_t cmd,
   input  wire logic              drive_req,
   input  wire logic              odt_pin,
   input  wire logic              write_burst,
   output      logic              rd_issue,
   output      logic              wr_issue,
   output      logic              issue_autopre,
   output      logic              dq_oe_n,
   output      logic              term_on,
   output      logic              term_is_wr,
   output      dmr_pkg::dmr_cfg_t cfg,
   output      logic              cfg_valid
);
   import dmr_pkg::*;

   typedef struct packed {
      logic                rst_meta;
      logic                rst_s;
      logic [ADDR_W-1:0]   mr0;
      logic [ADDR_W-1:0]   mr1;
      logic [ADDR_W-1:0]   mr2;
      logic [ADDR_W-1:0]   mr3;
      dmr_cfg_t            cfg;
      logic                tog;
      logic [AL_DEPTH-1:0] rd_sr;
      logic [AL_DEPTH-1:0] wr_sr;
      logic [AL_DEPTH-1:0] ap_sr;
      logic                rd_issue;
      logic                wr_issue;
      logic                issue_ap;
      logic                dq_oe_n;
      logic                term_on;
      logic                term_is_wr;
   } dmr_link_t;

   typedef struct packed {
      logic     tog_meta;
      logic     tog_s1;
      logic     tog_s2;
      dmr_cfg_t cfg;
      logic     cfg_valid;
   } dmr_sys_t;

   dmr_link_t lk_r;
   dmr_link_t lk_nxt;
   dmr_sys_t  sy_r;
   dmr_sys_t  sy_nxt;

   // link domain: everything facing the command pins
   always_comb begin
      logic       is_mrs;
      logic       is_rd;
      logic       is_wr;
      logic [1:0] al_code;
      logic [2:0] cwl_code;
      logic [3:0] al_idx;
      logic       is_ap;
      dmr_cfg_t   c;
      is_mrs   = 1'b0;
      is_rd    = 1'b0;
      is_wr    = 1'b0;
      al_code  = 2'h0;
      cwl_code = 3'h0;
      al_idx   = 4'h0;
      is_ap    = 1'b0;
      c        = '0;
      lk_nxt   = lk_r;
      // the link sees reset two ck_mem edges late, so reset must span three of them
      lk_nxt.rst_meta = reset;
      lk_nxt.rst_s    = lk_r.rst_meta;

      is_mrs = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
      is_rd  = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && cmd.we_n;
      is_wr  = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
      is_ap  = (is_rd || is_wr) && cmd.addr[CMD_AP_BIT];

      if (is_mrs) begin
         // ba[2] is not decoded: the two low bank bits pick one of four registers
         case (cmd.ba[1:0])
            BANK_MR0: lk_nxt.mr0 = cmd.addr;
            BANK_MR1: lk_nxt.mr1 = cmd.addr;
            BANK_MR2: lk_nxt.mr2 = cmd.addr;
            BANK_MR3: lk_nxt.mr3 = cmd.addr;
            default:  lk_nxt.mr0 = lk_r.mr0;
         endcase
         lk_nxt.tog = !lk_r.tog;
      end

      // decode from the next register values so the word is stable when the toggle flips
      c.drive_strength = {lk_nxt.mr1[MR1_DS_HI], lk_nxt.mr1[MR1_DS_LO]};
      c.rtt_nom = {lk_nxt.mr1[MR1_RTT_B2], lk_nxt.mr1[MR1_RTT_B1], lk_nxt.mr1[MR1_RTT_B0]};
      case (lk_nxt.mr2[MR2_RTTW_LO +: 2])
         RTTW_OFF:     c.rtt_wr = DMR_TERM_OFF;
         RTTW_QUARTER: c.rtt_wr = DMR_TERM_QUARTER;
         RTTW_HALF:    c.rtt_wr = DMR_TERM_HALF;
         default:      c.rtt_wr = DMR_TERM_RSVD;
      endcase
      // cas latency is a three-bit code on a base of four; A2 of that register is ignored
      c.cas_latency = CL_BASE + 5'(lk_nxt.mr0[MR0_CL_LO +: 3]);
      al_code = lk_nxt.mr1[MR1_AL_LO +: 2];
      case (al_code)
         AL_ZERO:  c.additive_latency = 5'h00;
         AL_CL_M1: c.additive_latency = c.cas_latency - 5'h01;
         AL_CL_M2: c.additive_latency = c.cas_latency - 5'h02;
         default:  c.additive_latency = 5'h00;
      endcase
      // a reserved write cas code falls back to the base setting of five, the fastest, and raises a flag
      cwl_code = lk_nxt.mr2[MR2_CWL_LO +: 3];
      c.cwl_reserved = cwl_code > CWL_MAX_CODE;
      c.write_cas_latency = c.cwl_reserved ? CWL_BASE : CWL_BASE + 4'(cwl_code);
      c.read_latency_total  = 6'(c.additive_latency) + 6'(c.cas_latency);
      c.write_latency_total = 6'(c.additive_latency) + 6'(c.write_cas_latency);
      c.output_off = lk_nxt.mr1[MR1_QOFF];
      c.self_refresh_double = lk_nxt.mr2[MR2_SRT];
      c.partial_array_refresh = lk_nxt.mr2[MR2_PARTIAL_ARRAY_REFRESH_LO +: 3];
      // bit n of the mask is bank n; banks outside it lose data only once self refresh is entered
      case (c.partial_array_refresh)
         3'h0:    c.keep_bank_mask = 8'hff;
         3'h1:    c.keep_bank_mask = 8'h0f;
         3'h2:    c.keep_bank_mask = 8'h03;
         3'h3:    c.keep_bank_mask = 8'h01;
         3'h4:    c.keep_bank_mask = 8'hfc;
         3'h5:    c.keep_bank_mask = 8'hf0;
         3'h6:    c.keep_bank_mask = 8'hc0;
         default: c.keep_bank_mask = 8'h80;
      endcase
      lk_nxt.cfg = c;

      // commands enter a shift line and leave al cycles later, the output flop included
      lk_nxt.rd_sr = {lk_r.rd_sr[AL_DEPTH-2:0], is_rd};
      lk_nxt.wr_sr = {lk_r.wr_sr[AL_DEPTH-2:0], is_wr};
      lk_nxt.ap_sr = {lk_r.ap_sr[AL_DEPTH-2:0], is_ap};
      // latency is read at shift-out, so changing it with commands in flight moves them
      al_idx = 4'(lk_r.cfg.additive_latency - 5'h01);
      if (lk_r.cfg.additive_latency == 5'h00) begin
         lk_nxt.rd_issue = is_rd;
         lk_nxt.wr_issue = is_wr;
         lk_nxt.issue_ap = is_ap;
      end else begin
         lk_nxt.rd_issue = lk_r.rd_sr[al_idx];
         lk_nxt.wr_issue = lk_r.wr_sr[al_idx];
         lk_nxt.issue_ap = lk_r.ap_sr[al_idx];
      end

      // low means drive; the output-off bit overrides whatever the core asks for
      lk_nxt.dq_oe_n = !(drive_req && !lk_r.cfg.output_off);
      // during writes the write value wins; a disabled nominal does not block it
      lk_nxt.term_is_wr = odt_pin && write_burst && (lk_r.cfg.rtt_wr != DMR_TERM_OFF);
      lk_nxt.term_on = odt_pin && (lk_nxt.term_is_wr || (lk_r.cfg.rtt_nom != RTT_NOM_OFF));

      if (lk_r.rst_s) begin
         lk_nxt     = '0;
         lk_nxt.mr0 = MR_RESET;
         lk_nxt.mr1 = MR_RESET;
         lk_nxt.mr2 = MR_RESET;
         lk_nxt.mr3 = MR_RESET;
         // drivers stay off while the link side is held in reset
         lk_nxt.dq_oe_n  = 1'b1;
         lk_nxt.rst_meta = reset;
         lk_nxt.rst_s    = lk_r.rst_meta;
      end
   end

   always_ff @(posedge ck_mem) begin
      lk_r <= lk_nxt;
   end

   // system domain: capture the decoded word once the toggle has settled
   always_comb begin
      sy_nxt = sy_r;
      sy_nxt.tog_meta = lk_r.tog;
      sy_nxt.tog_s1   = sy_r.tog_meta;
      sy_nxt.tog_s2   = sy_r.tog_s1;
      // a second mode set within about three clk_sys cycles can be skipped; command spacing prevents it
      if (sy_r.tog_s1 != sy_r.tog_s2) begin
         sy_nxt.cfg       = lk_r.cfg;
         sy_nxt.cfg_valid = 1'b1;
      end
      if (reset) begin
         sy_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      sy_r <= sy_nxt;
   end

   // every output below is a flop of one of the two state words
   assign rd_issue      = lk_r.rd_issue;
   assign wr_issue      = lk_r.wr_issue;
   assign issue_autopre = lk_r.issue_ap;
   assign dq_oe_n       = lk_r.dq_oe_n;
   assign term_on       = lk_r.term_on;
   assign term_is_wr    = lk_r.term_is_wr;
   assign cfg           = sy_r.cfg;
   assign cfg_valid     = sy_r.cfg_valid;
endmodule
